//--- logic/tw_cfg.svh
/*
 * Offsets, field positions, reset values and fixed tops of the waveform timer.
 * Assumes a 32-bit APB slave with byte addresses, one register per word.
 */
`ifndef TW_CFG_SVH
`define TW_CFG_SVH
// Register byte offsets
`define TW_OFF_CTRLA 8'h00
`define TW_OFF_CTRLB 8'h04
`define TW_OFF_COUNT 8'h08
`define TW_OFF_CMPA 8'h0c
`define TW_OFF_CMPB 8'h10
`define TW_OFF_CMPC 8'h14
`define TW_OFF_CAPT 8'h18
`define TW_OFF_STAT 8'h1c
// Field positions
`define TW_A_ACT_A_LSB 6
`define TW_ACT_STEP 2
`define TW_A_WGM_LSB 0
`define TW_B_WGM_LSB 3
`define TW_B_CS_LSB 0
`define TW_B_WMASK 8'hdf
`define TW_STAT_OVF 0
`define TW_CTRL_RESET 8'h00
// Count limits
`define TW_MAX 16'hffff
`define TW_BOTTOM 16'h0000
`define TW_TOP_8 16'h00ff
`define TW_TOP_9 16'h01ff
`define TW_TOP_10 16'h03ff
// Clock source codes and prescaler masks
`define TW_CS_STOP 3'h0
`define TW_CS_DIV1 3'h1
`define TW_CS_DIV8 3'h2
`define TW_CS_DIV64 3'h3
`define TW_CS_DIV256 3'h4
`define TW_CS_DIV1024 3'h5
`define TW_CS_EXT_FALL 3'h6
`define TW_CS_EXT_RISE 3'h7
`define TW_PRE_8 10'h007
`define TW_PRE_64 10'h03f
`define TW_PRE_256 10'h0ff
`define TW_PRE_1024 10'h3ff
`endif

//--- logic/tw_pkg.sv
/*
 * Types shared by the waveform timer and its bench.
 * Assumes the APB master drives the request fields on the same clock.
 */
package tw_pkg;
	// APB request carried as one bundle
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} tw_apb_req_t;
	// Count shape of the selected mode
	typedef enum logic [1:0] {SLOPE_SINGLE, SLOPE_FAST, SLOPE_DUAL} tw_slope_t;
	// Event that reloads compare values or raises the overflow flag
	typedef enum logic [1:0] {AT_NOW, AT_MAX, AT_TOP, AT_BOT} tw_point_t;
endpackage

//--- logic/tw_timer.sv
/*
 * Sixteen-bit timer with three compare channels and waveform modes, APB slave.
 * Assumes portData/portDirOut come from the port logic on clk; extCountPin is async.
 */
`timescale 1ns/100ps
`include "tw_cfg.svh"

// Operation
// RULE_01: Nonzero channel action field routes compare output to the pin.
// RULE_02: Pin driver enabled only while its direction bit selects output.
// RULE_03: Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// RULE_04: PWM code 01: off unless top mode bit set; then toggle A only.
// RULE_05: Fast PWM 10: clear on match, set at top.
// RULE_06: Fast PWM 11: set on match, clear at top.
// RULE_07: Fast PWM compare equal to top with upper bit: only top action.
// RULE_08: Dual slope 10: clear on up match, set on down match.
// RULE_09: Dual slope 11: set on up match, clear on down match.
// RULE_10: Mode is control B bits 4:3 over control A bits 1:0.
// RULE_11: Sixteen mode codes fix sequence, top, reload and flag; 13 reserved.
// RULE_12: Codes 1-3 and 5-7 use fixed tops, reload at top.
// RULE_13: Codes 0, 4, 12: top max, A or capture; immediate; flag at max.
// RULE_14: Codes 8-9 reload at bottom, 10-11 at top; flag at bottom.
// RULE_15: Codes 14-15 fast PWM, capture or A top; reload and flag at top.
// RULE_16: Control A holds channel actions in bits 7:6, 5:4, 3:2.
// RULE_17: Clock source zero stops; else divide 1..1024 or external edge.
// RULE_18: Capture pin disconnected whenever capture value is top.
// RULE_19: Dual slope compare at bottom holds low, at top holds high; action code 11 holds the opposite levels.
// RULE_20: Both control registers reset to zero.
// RULE_21: Control B bit 5 reads zero, writes ignored.
module tw_timer #(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire tw_pkg::tw_apb_req_t apbReq,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic extCountPin,
	input wire logic [2:0] portData,
	input wire logic [2:0] portDirOut,
	output logic [2:0] compareOutPin,
	output logic [2:0] compareOutOe,
	output logic captureInputEnable,
	output logic overflowFlag
);
	import tw_pkg::*;

	// Tops and offsets are fixed at sixteen bits
	if (CNT_W != 16) begin : g_chk
		$error("tw_timer supports CNT_W of 16 only");
	end

	////////////////////////////////////////////////////////////////////////
	logic [7:0] ctrlA_reg, ctrlA_next, ctrlB_reg, ctrlB_next;
	logic [15:0] count_reg, count_next, capt_reg, capt_next;
	logic [15:0] cmpBuf_reg [3], cmpBuf_next [3], cmpAct_reg [3], cmpAct_next [3];
	logic [2:0] oc_reg, oc_next, pin_reg, pin_next;
	logic dirUp_reg, dirUp_next, ovf_reg, ovf_next;
	logic [9:0] pre_reg, pre_next;
	logic extS1_reg, extS2_reg, extPrev_reg, extPrev_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [3:0] mode;
	tw_slope_t slope;
	tw_point_t reload, ovfAt;
	logic [15:0] top;
	logic tick, atTop, atBot, wr, hit, usesCapt;
	logic [1:0] act;
	logic match, pwm, conn;

	// Mode decode from the split field
	always_comb begin
		mode = {ctrlB_reg[`TW_B_WGM_LSB +: 2], ctrlA_reg[`TW_A_WGM_LSB +: 2]}; // [RULE_10]
		slope = SLOPE_SINGLE;
		reload = AT_NOW;
		ovfAt = AT_MAX;
		top = `TW_MAX;
		usesCapt = 1'b0;
		case (mode[3:2]) // [RULE_11]
			2'b00: begin
				if (mode[1:0] != 2'b00) begin
					slope = SLOPE_DUAL; // [RULE_12]
					reload = AT_TOP;
					ovfAt = AT_BOT;
				end
			end
			2'b01: begin
				if (mode[1:0] == 2'b00) begin
					top = cmpAct_reg[0]; // [RULE_13]
				end else begin
					slope = SLOPE_FAST; // [RULE_12]
					reload = AT_TOP;
					ovfAt = AT_TOP;
				end
			end
			2'b10: begin
				slope = SLOPE_DUAL; // [RULE_14]
				reload = mode[1] ? AT_TOP : AT_BOT;
				ovfAt = AT_BOT;
				usesCapt = !mode[0];
				top = mode[0] ? cmpAct_reg[0] : capt_reg;
			end
			2'b11: begin
				// Reserved code 13 falls back to a free count to max
				if (mode[1]) begin
					slope = SLOPE_FAST; // [RULE_15]
					reload = AT_TOP;
					ovfAt = AT_TOP;
					usesCapt = !mode[0];
					top = mode[0] ? cmpAct_reg[0] : capt_reg;
				end else if (!mode[0]) begin
					usesCapt = 1'b1; // [RULE_13]
					top = capt_reg;
				end
			end
			default: begin
				top = `TW_MAX;
			end
		endcase
		if (mode[3:2] == 2'b00 || mode[3:2] == 2'b01) begin
			case (mode[1:0])
				2'b01: top = (mode[2] || slope == SLOPE_DUAL) ? `TW_TOP_8 : top;
				2'b10: top = `TW_TOP_9;
				2'b11: top = `TW_TOP_10;
				default: top = top;
			endcase
		end
	end

	// Clock source selection
	always_comb begin
		pre_next = pre_reg + 10'h001;
		extPrev_next = extS2_reg;
		case (ctrlB_reg[`TW_B_CS_LSB +: 3]) // [RULE_17]
			`TW_CS_STOP: tick = 1'b0;
			`TW_CS_DIV1: tick = 1'b1;
			`TW_CS_DIV8: tick = (pre_reg & `TW_PRE_8) == `TW_PRE_8;
			`TW_CS_DIV64: tick = (pre_reg & `TW_PRE_64) == `TW_PRE_64;
			`TW_CS_DIV256: tick = (pre_reg & `TW_PRE_256) == `TW_PRE_256;
			`TW_CS_DIV1024: tick = pre_reg == `TW_PRE_1024;
			`TW_CS_EXT_FALL: tick = extPrev_reg && !extS2_reg;
			`TW_CS_EXT_RISE: tick = !extPrev_reg && extS2_reg;
			default: tick = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Counter, reload, flag, compare outputs and registers
	always_comb begin
		wr = apbReq.psel && apbReq.penable && apbReq.pwrite;
		atTop = count_reg == top;
		atBot = count_reg == `TW_BOTTOM;
		ctrlA_next = ctrlA_reg;
		ctrlB_next = ctrlB_reg;
		count_next = count_reg;
		capt_next = capt_reg;
		dirUp_next = dirUp_reg;
		ovf_next = ovf_reg;
		oc_next = oc_reg;
		cmpBuf_next = cmpBuf_reg;
		cmpAct_next = cmpAct_reg;
		pwm = slope != SLOPE_SINGLE;
		act = 2'b00;
		match = 1'b0;
		conn = 1'b0;
		pin_next = pin_reg;
		// Count sequence
		if (tick) begin
			if (slope == SLOPE_DUAL) begin
				if (dirUp_reg && count_reg >= top) begin
					dirUp_next = 1'b0;
					count_next = count_reg - 16'h0001;
				end else if (!dirUp_reg && atBot) begin
					dirUp_next = 1'b1;
					count_next = count_reg + 16'h0001;
				end else begin
					count_next = dirUp_reg ? count_reg + 16'h0001 : count_reg - 16'h0001;
				end
			end else begin
				dirUp_next = 1'b1;
				count_next = (count_reg >= top) ? `TW_BOTTOM : count_reg + 16'h0001;
			end
		end
		// Compare reload point
		for (int i = 0; i < 3; i++) begin
			if (reload == AT_NOW || (tick && reload == AT_TOP && atTop) ||
					(tick && reload == AT_BOT && atBot)) begin
				cmpAct_next[i] = cmpBuf_reg[i]; // [RULE_13] [RULE_14]
			end
		end
		// Overflow flag point; a set beats a clear in the same cycle
		if (wr && apbReq.paddr == `TW_OFF_STAT && apbReq.pwdata[`TW_STAT_OVF]) begin
			ovf_next = 1'b0;
		end
		if (tick && ((ovfAt == AT_MAX && count_reg == `TW_MAX) ||
				(ovfAt == AT_TOP && atTop) || (ovfAt == AT_BOT && atBot))) begin
			ovf_next = 1'b1; // [RULE_12] [RULE_15]
		end
		// Per-channel waveform
		for (int i = 0; i < 3; i++) begin
			act = ctrlA_reg[`TW_A_ACT_A_LSB - `TW_ACT_STEP * i +: 2]; // [RULE_16]
			match = tick && count_reg == cmpAct_reg[i];
			if (act == 2'b01) begin
				// Toggle on match for any channel outside PWM; in PWM only channel A with the top mode bit
				if ((!pwm || (mode[3] && i == 0)) && match) begin
					oc_next[i] = !oc_reg[i]; // [RULE_03] [RULE_04]
				end
			end else if (act[1]) begin
				if (slope == SLOPE_SINGLE) begin
					if (match) begin
						oc_next[i] = act[0]; // [RULE_03]
					end
				end else if (slope == SLOPE_FAST) begin
					if (match && cmpAct_reg[i] != top) begin
						oc_next[i] = act[0]; // [RULE_05] [RULE_06] [RULE_07]
					end
					if (tick && atTop) begin
						oc_next[i] = !act[0]; // [RULE_05] [RULE_06]
					end
				end else begin
					// Extremes pinned so the output never glitches at the turn
					if (cmpAct_reg[i] == `TW_BOTTOM) begin
						oc_next[i] = act[0]; // [RULE_19]
					end else if (cmpAct_reg[i] == top) begin
						oc_next[i] = !act[0]; // [RULE_19]
					end else if (match) begin
						oc_next[i] = dirUp_reg ? act[0] : !act[0]; // [RULE_08] [RULE_09]
					end
				end
			end
			conn = act != 2'b00 && !(pwm && act == 2'b01 && !(mode[3] && i == 0));
			pin_next[i] = conn ? oc_next[i] : portData[i]; // [RULE_01] [RULE_04]
		end
		// Register writes; counter write wins over the tick
		if (wr) begin
			case (apbReq.paddr)
				`TW_OFF_CTRLA: ctrlA_next = apbReq.pwdata[7:0];
				`TW_OFF_CTRLB: ctrlB_next = apbReq.pwdata[7:0] & `TW_B_WMASK; // [RULE_21]
				`TW_OFF_COUNT: count_next = apbReq.pwdata[15:0];
				`TW_OFF_CMPA: cmpBuf_next[0] = apbReq.pwdata[15:0];
				`TW_OFF_CMPB: cmpBuf_next[1] = apbReq.pwdata[15:0];
				`TW_OFF_CMPC: cmpBuf_next[2] = apbReq.pwdata[15:0];
				`TW_OFF_CAPT: capt_next = apbReq.pwdata[15:0];
				default: ctrlA_next = ctrlA_reg;
			endcase
		end
	end

	// Read data captured in the setup cycle
	always_comb begin
		hit = 1'b1;
		rdata_next = rdata_reg;
		case (apbReq.paddr)
			`TW_OFF_CTRLA: rdata_next = {24'h000000, ctrlA_reg};
			`TW_OFF_CTRLB: rdata_next = {24'h000000, ctrlB_reg};
			`TW_OFF_COUNT: rdata_next = {16'h0000, count_reg};
			`TW_OFF_CMPA: rdata_next = {16'h0000, cmpBuf_reg[0]};
			`TW_OFF_CMPB: rdata_next = {16'h0000, cmpBuf_reg[1]};
			`TW_OFF_CMPC: rdata_next = {16'h0000, cmpBuf_reg[2]};
			`TW_OFF_CAPT: rdata_next = {16'h0000, capt_reg};
			`TW_OFF_STAT: rdata_next = {31'h00000000, ovf_reg};
			default: begin
				hit = 1'b0;
				rdata_next = 32'h00000000;
			end
		endcase
		if (!(apbReq.psel && !apbReq.penable)) begin
			rdata_next = rdata_reg;
		end
	end

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = apbReq.psel && apbReq.penable && !hit;
	assign prdata = rdata_reg;
	assign compareOutPin = pin_reg;
	assign compareOutOe = portDirOut; // [RULE_02]
	assign captureInputEnable = !usesCapt; // [RULE_18]
	assign overflowFlag = ovf_reg;

	////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrlA_reg <= `TW_CTRL_RESET; // [RULE_20]
			ctrlB_reg <= `TW_CTRL_RESET; // [RULE_20]
			count_reg <= `TW_BOTTOM;
			capt_reg <= `TW_BOTTOM;
			for (int i = 0; i < 3; i++) begin
				cmpBuf_reg[i] <= `TW_BOTTOM;
				cmpAct_reg[i] <= `TW_BOTTOM;
			end
			oc_reg <= 3'h0;
			pin_reg <= 3'h0;
			dirUp_reg <= 1'b1;
			ovf_reg <= 1'b0;
			pre_reg <= 10'h000;
			extS1_reg <= 1'b0;
			extS2_reg <= 1'b0;
			extPrev_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			ctrlA_reg <= ctrlA_next;
			ctrlB_reg <= ctrlB_next;
			count_reg <= count_next;
			capt_reg <= capt_next;
			cmpBuf_reg <= cmpBuf_next;
			cmpAct_reg <= cmpAct_next;
			oc_reg <= oc_next;
			pin_reg <= pin_next;
			dirUp_reg <= dirUp_next;
			ovf_reg <= ovf_next;
			pre_reg <= pre_next;
			extS1_reg <= extCountPin;
			extS2_reg <= extS1_reg;
			extPrev_reg <= extPrev_next;
			rdata_reg <= rdata_next;
		end
	end
endmodule

//--- testbench/tw_timer_properties.sv
/* Port checker for the waveform timer.
   Assumes bind onto tw_timer; control registers mirrored from APB writes. */
`timescale 1ns/100ps
`include "tw_cfg.svh"
module tw_timer_properties (
	input wire logic clk,
	input wire logic resetn,
	input wire tw_pkg::tw_apb_req_t apbReq,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic extCountPin,
	input wire logic [2:0] portData,
	input wire logic [2:0] portDirOut,
	input wire logic [2:0] compareOutPin,
	input wire logic [2:0] compareOutOe,
	input wire logic captureInputEnable,
	input wire logic overflowFlag
);
	import tw_pkg::*;
	logic [7:0] ctrlA_reg, ctrlA_next, ctrlB_reg, ctrlB_next;
	logic wr, rd, offA, offB, capTop, stop, clrOvf;
	logic [3:0] mode;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	// Decoded view of the mirrored control bits
	assign wr = apbReq.psel & apbReq.penable & apbReq.pwrite;
	assign rd = apbReq.psel & apbReq.penable & !apbReq.pwrite;
	assign mode = {ctrlB_reg[4:3], ctrlA_reg[1:0]};
	assign offA = ctrlA_reg[7:6] == 2'h0;
	assign offB = ctrlA_reg[5:4] == 2'h1 && mode inside {[4'h1:4'h3], [4'h5:4'h7]};
	assign capTop = mode inside {4'h8, 4'ha, 4'hc, 4'he};
	assign stop = ctrlB_reg[2:0] == `TW_CS_STOP;
	assign clrOvf = wr && apbReq.paddr == `TW_OFF_STAT && apbReq.pwdata[0];
	// Mirror updates on the same edge as the slave
	always_comb begin
		ctrlA_next = ctrlA_reg;
		ctrlB_next = ctrlB_reg;
		if (wr && apbReq.paddr == `TW_OFF_CTRLA) ctrlA_next = apbReq.pwdata[7:0];
		if (wr && apbReq.paddr == `TW_OFF_CTRLB) ctrlB_next = apbReq.pwdata[7:0] & `TW_B_WMASK;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrlA_reg <= 8'h00;
			ctrlB_reg <= 8'h00;
		end else begin
			ctrlA_reg <= ctrlA_next;
			ctrlB_reg <= ctrlB_next;
		end
	end
	sequence s_readB;
		rd && apbReq.paddr == `TW_OFF_CTRLB;
	endsequence
	sequence s_readA;
		rd && apbReq.paddr == `TW_OFF_CTRLA;
	endsequence
	a_oe_follows_dir: assert property (compareOutOe == portDirOut)
		else $error("pin enable differs from direction");
	a_port_path_a: assert property ($past(offA) && $past(resetn) |->
		compareOutPin[0] == $past(portData[0])) else $error("pin A not port data");
	a_code01_off_b: assert property ($past(offB) && $past(resetn) |->
		compareOutPin[1] == $past(portData[1])) else $error("pin B not port data");
	a_capture_pin_off: assert property (captureInputEnable != capTop)
		else $error("capture enable wrong for mode");
	a_ctrlb_bit5_zero: assert property (s_readB |-> prdata[5] == 1'b0)
		else $error("control B bit 5 read as one");
	a_ctrla_read_back: assert property (s_readA |-> prdata == {24'h0, ctrlA_reg})
		else $error("control A read mismatch");
	a_ovf_clear_only: assert property ($fell(overflowFlag) |-> $past(clrOvf))
		else $error("overflow fell without clear");
	a_stopped_no_ovf: assert property (stop [*3] ##0 !overflowFlag |=> !overflowFlag)
		else $error("overflow while stopped");
endmodule
bind tw_timer tw_timer_properties u_props (.clk(clk), .resetn(resetn), .apbReq(apbReq),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .extCountPin(extCountPin),
	.portData(portData), .portDirOut(portDirOut), .compareOutPin(compareOutPin),
	.compareOutOe(compareOutOe), .captureInputEnable(captureInputEnable),
	.overflowFlag(overflowFlag));

//--- testbench/tw_pin_load.sv
/* Loads on the three compare pins.
   Assumes pull-downs: a pin not driven reads low. */
`timescale 1ns/100ps
module tw_pin_load (
	input wire logic [2:0] pinOut,
	input wire logic [2:0] pinOe,
	output logic [2:0] pinLevel
);
	// Undriven pins settle at the pull-down level
	assign pinLevel = pinOut & pinOe;
endmodule

//--- testbench/tb_timer16_waveform_mode_control.sv
/* Bench for the waveform timer: APB master, pin loads, scenario tasks.
   Assumes an APB slave on the same 25 ns clock; the master waits for pready. */
`timescale 1ns/100ps
`include "tw_cfg.svh"
module tb_timer16_waveform_mode_control;
	import tw_pkg::*;
	logic clk, resetn, pready, pslverr, capEn, ovf, slvErr, extPin;
	logic [2:0] pData, pDir, pinQ, pinOe, pinLevel;
	logic [31:0] prdata, rdata;
	tw_apb_req_t req;
	int errCount = 0, nChecks = 0, cycles = 0;
	tw_timer dut (.clk(clk), .resetn(resetn), .apbReq(req), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .extCountPin(extPin), .portData(pData), .portDirOut(pDir),
		.compareOutPin(pinQ), .compareOutOe(pinOe), .captureInputEnable(capEn),
		.overflowFlag(ovf));
	tw_pin_load u_load (.pinOut(pinQ), .pinOe(pinOe), .pinLevel(pinLevel));
	////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			errCount++;
			summarize();
		end
	end
	task automatic summarize();
		if (errCount == 0 && nChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			errCount++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One APB transfer, then an idle cycle so req never changes twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdata = prdata;
		slvErr = pslverr;
		req <= '0;
		@(posedge clk);
	endtask
	task automatic t_regs();
		apb(1'b0, `TW_OFF_CTRLA, 32'h0);
		chk(rdata, 32'h0);
		apb(1'b0, `TW_OFF_CTRLB, 32'h0);
		chk(rdata, 32'h0);
		apb(1'b1, `TW_OFF_CTRLB, 32'hff);
		apb(1'b0, `TW_OFF_CTRLB, 32'h0);
		chk(rdata, 32'hdf);
		apb(1'b1, `TW_OFF_CTRLA, 32'hfc);
		apb(1'b0, `TW_OFF_CTRLA, 32'h0);
		chk(rdata, 32'hfc);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, slvErr}, 32'h1);
		apb(1'b1, `TW_OFF_CTRLB, 32'h0);
	endtask
	task automatic t_port();
		apb(1'b1, `TW_OFF_CTRLA, 32'h0);
		pData <= 3'h7;
		pDir <= 3'h5;
		repeat (3) @(posedge clk);
		chk({29'h0, pinLevel}, 32'h5);
		apb(1'b1, `TW_OFF_CTRLA, 32'h11);
		apb(1'b1, `TW_OFF_CTRLB, 32'h1);
		pDir <= 3'h7;
		repeat (3) @(posedge clk);
		chk({31'h0, pinLevel[1]}, 32'h1);
	endtask
	// Set, clear, then toggle from low, each on one match at 0x20
	task automatic t_nonpwm();
		logic [7:0] act [3] = '{8'hc0, 8'h80, 8'h40};
		logic exp [3] = '{1'b1, 1'b0, 1'b1};
		apb(1'b1, `TW_OFF_CMPA, 32'h20);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `TW_OFF_CTRLA, {24'h0, act[i]});
			apb(1'b1, `TW_OFF_COUNT, 32'h0);
			repeat (60) @(posedge clk);
			chk({31'h0, pinLevel[0]}, {31'h0, exp[i]});
		end
	endtask
	// Pin A must read one level at four samples 150 cycles apart, in fast or dual-slope PWM
	task automatic steady(input logic [7:0] ca, input logic [7:0] cb, input logic [15:0] cmp,
		input logic exp);
		apb(1'b1, `TW_OFF_CMPA, {16'h0, cmp});
		apb(1'b1, `TW_OFF_CTRLA, {24'h0, ca});
		apb(1'b1, `TW_OFF_CTRLB, {24'h0, cb});
		repeat (1100) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			repeat (150) @(posedge clk);
			chk({31'h0, pinLevel[0]}, {31'h0, exp});
		end
	endtask
	task automatic t_fast();
		steady(8'h81, 8'h09, 16'h00ff, 1'b1);
		steady(8'hc1, 8'h09, 16'h00ff, 1'b0);
	endtask
	task automatic t_dual();
		steady(8'h81, 8'h01, 16'h0000, 1'b0);
		steady(8'h81, 8'h01, 16'h00ff, 1'b1);
		steady(8'hc1, 8'h01, 16'h0000, 1'b1);
		steady(8'hc1, 8'h01, 16'h00ff, 1'b0);
	endtask
	// High cycles of pin A over whole periods, sampled away from the launching edge
	task automatic duty(input logic [7:0] cb, input int win, input int exp);
		logic [31:0] hi;
		hi = 32'h0;
		apb(1'b1, `TW_OFF_CTRLB, {24'h0, cb});
		repeat (600) @(posedge clk);
		repeat (win) begin
			@(negedge clk);
			hi = hi + {31'h0, pinLevel[0]};
		end
		@(posedge clk);
		chk(hi, exp);
	endtask
	// Real waveforms at compare 0x40: fast 65 of 256, dual slope 128 of 510
	task automatic t_pwm();
		apb(1'b1, `TW_OFF_CMPA, 32'h40);
		apb(1'b1, `TW_OFF_CTRLA, 32'h81);
		duty(8'h09, 256, 65);
		duty(8'h01, 510, 128);
		apb(1'b1, `TW_OFF_CTRLA, 32'hc1);
		duty(8'h01, 510, 382);
		duty(8'h09, 256, 191);
		apb(1'b1, `TW_OFF_CTRLA, 32'h43);
		duty(8'h19, 130, 65);
	endtask
	// Divide by 8 over exactly 80 cycles, then three rising and three falling pin edges
	task automatic t_clk();
		apb(1'b1, `TW_OFF_CTRLB, 32'h0);
		apb(1'b1, `TW_OFF_COUNT, 32'h0);
		apb(1'b1, `TW_OFF_CTRLB, 32'h2);
		repeat (77) @(posedge clk);
		apb(1'b1, `TW_OFF_CTRLB, 32'h0);
		apb(1'b0, `TW_OFF_COUNT, 32'h0);
		chk(rdata, 32'ha);
		apb(1'b1, `TW_OFF_COUNT, 32'h0);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, `TW_OFF_CTRLB, 32'h7 - k);
			repeat (3) begin
				extPin <= 1'b1;
				repeat (4) @(posedge clk);
				extPin <= 1'b0;
				repeat (4) @(posedge clk);
			end
		end
		apb(1'b1, `TW_OFF_CTRLB, 32'h0);
		apb(1'b0, `TW_OFF_COUNT, 32'h0);
		chk(rdata, 32'h6);
	endtask
	task automatic t_capture();
		for (int m = 0; m < 16; m++) begin
			apb(1'b1, `TW_OFF_CTRLA, m & 3);
			apb(1'b1, `TW_OFF_CTRLB, (m >> 2) << 3);
			chk({31'h0, capEn}, {31'h0, !(m inside {8, 10, 12, 14})});
		end
	endtask
	task automatic t_ovf();
		apb(1'b1, `TW_OFF_CTRLA, 32'h0);
		apb(1'b1, `TW_OFF_STAT, 32'h1);
		repeat (5) @(posedge clk);
		chk({31'h0, ovf}, 32'h0);
		apb(1'b1, `TW_OFF_COUNT, 32'hfff0);
		apb(1'b1, `TW_OFF_CTRLB, 32'h1);
		repeat (40) @(posedge clk);
		chk({31'h0, ovf}, 32'h1);
		apb(1'b0, `TW_OFF_STAT, 32'h0);
		chk(rdata, 32'h1);
		apb(1'b1, `TW_OFF_STAT, 32'h1);
		chk({31'h0, ovf}, 32'h0);
	endtask
	initial begin
		resetn = 1'b0;
		req = '0;
		pData = 3'h0;
		pDir = 3'h0;
		extPin = 1'b0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		t_regs();
		t_port();
		t_nonpwm();
		t_fast();
		t_dual();
		t_pwm();
		t_capture();
		t_ovf();
		t_clk();
		summarize();
	end
endmodule
